/* File: inc/dual_ddr_pkg.sv */
// Shared constants and types for the dual DDR port receiver and its host end
package dual_ddr_pkg;
  localparam int SAMPLE_W = 14;
  localparam int PAIR_W = 28;
  localparam int HIST_DEPTH = 8;
  localparam int TAP_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW = 2;
  localparam int LAT_PAD = 70;
  localparam logic [SAMPLE_W-1:0] MIDSCALE = 14'h2000;
  // Device configuration map, byte wide
  localparam logic [7:0] A_WIN_STATUS = 8'h0c;
  localparam logic [7:0] A_RX_CTRL = 8'h10;
  localparam logic [7:0] A_CLK_DLY = 8'h11;
  localparam logic [7:0] A_SMP_DLY = 8'h12;
  localparam logic [7:0] A_WIN_SKEW = 8'h13;
  localparam logic [7:0] A_RX_STATUS = 8'h21;
  localparam int B_EN = 0;
  localparam int B_LOOP_ON = 1;
  localparam int B_FLAG_RST = 2;
  localparam int B_EARLY = 2;
  localparam int B_LATE = 0;
  localparam int B_LOCKED = 0;
  localparam int B_LOST = 1;
  localparam int B_TRACK = 3;
  localparam logic [7:0] DLY_RST = 8'ha7;
  localparam logic [3:0] SKEW_RST = 4'h0;
  localparam logic [7:0] DLY_MAX = 8'hff;
  localparam logic [5:0] AVG_STEP = 6'h04;
  localparam logic [3:0] LOST_LIMIT = 4'h8;
  // Time step of one skew code in ps, and the top code
  localparam int SKEW_STEP_PS = 12;
  localparam logic [3:0] SKEW_TOP = 4'hf;
  // Host register map on AHB-Lite
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_CFG = 8'h04;
  localparam logic [7:0] H_STATUS = 8'h08;
  localparam int H_CFG_RD = 16;
  localparam int H_IRQ = 8;
  localparam int H_RET_SEEN = 9;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_SEARCH = 4'b0010,
    ST_TRACK = 4'b0100,
    ST_LOST = 4'b1000
  } rx_state_t;
endpackage : dual_ddr_pkg

/* File: inc/ddr_link_if.sv */
// Link between host and receiver: two DDR sample ports, clocks and config port
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if;
  import dual_ddr_pkg::*;
  logic [SAMPLE_W-1:0] even_sample_port;
  logic [SAMPLE_W-1:0] odd_sample_port;
  logic forwarded_data_clock;
  logic returned_clock_out;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic lock_irq;
  modport device (input even_sample_port, odd_sample_port, forwarded_data_clock, cfg_wr, cfg_rd, cfg_addr,
    cfg_wdata, output returned_clock_out, cfg_rdata, lock_irq);
  modport host (output even_sample_port, odd_sample_port, forwarded_data_clock, cfg_wr, cfg_rd, cfg_addr,
    cfg_wdata, input returned_clock_out, cfg_rdata, lock_irq);
endinterface : ddr_link_if
`default_nettype wire

/* File: hw/elastic_fifo.sv */
// Small synchronous elastic FIFO for captured sample pairs
`timescale 1ns/1ps
`default_nettype none
module elastic_fifo (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic flush,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [dual_ddr_pkg::PAIR_W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [dual_ddr_pkg::PAIR_W-1:0] rd_data,
  output logic [dual_ddr_pkg::FIFO_AW:0] fill
);
  import dual_ddr_pkg::*;
  logic [PAIR_W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_AW:0] wp_q;
  logic [FIFO_AW:0] rp_q;
  logic do_wr;
  logic do_rd;

  assign fill = wp_q - rp_q;
  assign wr_ready = (fill != (FIFO_AW+1)'(FIFO_DEPTH));
  assign rd_valid = (fill != '0);
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;
  assign rd_data = mem_q[rp_q[FIFO_AW-1:0]];

  always_ff @(posedge hclk) begin
    if (do_wr) begin
      mem_q[wp_q[FIFO_AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule : elastic_fifo
`default_nettype wire

/* File: hw/ddr_port_receiver.sv */
// Receiver end: delay-locked capture, elastic FIFO, assembler and returned clock
//
// Summary of operation
// - Two 14-bit ports, each at half rate
// - Host sends offset binary, odd/even split
// - Host forwards quarter-rate 0101 clock with data
// - Return quarter-rate clock to host
// - Sample 90 degrees after clock, both edges
// - Reassemble even/odd streams in order
// - Port to output latency near 78 cycles
// - Elastic FIFO into converter clock domain
// - Enable plus loop-on runs continuous tracking
// - Track skew drift after lock
// - Early/late samples in 0x0C bits 2,0
// - Average window samples before any decision
// - Skew width in 0x13; narrow means slower
// - Host programs skew 0x72 at init
// - Clock and sample delays share divider timing
// - Divide-by-4 phases drive controller and return
// - Accept 1.6 to 2.5 GSPS update rates
// - Interrupt output on loss of lock
// - Host initializes controllers before data; the bench sets the H_CTRL stream enable first
// - Lock in 0x21 bit0; loop-on restarts
// - Host enables with 0x02 then 0x03
`timescale 1ns/1ps
`default_nettype none
module ddr_port_receiver (
  input wire logic hclk,
  input wire logic hresetn,
  ddr_link_if.device link,
  output logic [dual_ddr_pkg::SAMPLE_W-1:0] converter_sample,
  output logic receiver_locked
);
  import dual_ddr_pkg::*;

  // Divide-by-4 phases of the master clock
  logic [1:0] div_q;
  logic [1:0] ret_div_q;
  logic returned_q;
  // Delay lines of the forwarded clock and the data pair
  logic [HIST_DEPTH-1:0] clk_hist_q;
  logic [PAIR_W-1:0] data_hist_q [HIST_DEPTH];
  logic [7:0] clock_path_delay_q;
  logic [7:0] sample_path_delay_q;
  logic [3:0] window_skew_width_q;
  logic en_q;
  logic receiver_loop_on_q;
  logic flag_rst_q;
  rx_state_t state_q;
  logic early_window_sample_q;
  logic late_window_sample_q;
  // Seven bits: the widest averaging period is 64 votes
  logic [6:0] avg_cnt_q;
  logic [6:0] early_votes_q;
  logic [6:0] late_votes_q;
  logic lose_lock;
  logic [3:0] miss_q;
  logic lost_q;
  logic [7:0] rdata_q;
  logic [TAP_W-1:0] clk_tap;
  logic [TAP_W-1:0] early_tap;
  logic [TAP_W-1:0] smp_tap;
  logic [6:0] avg_len;
  logic avg_done;
  logic too_early;
  logic too_late;
  logic centred;
  logic running;
  logic cap_lo_q;
  logic [SAMPLE_W-1:0] cap_even_q;
  logic [SAMPLE_W-1:0] cap_odd_q;
  logic cap_valid_q;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [PAIR_W-1:0] fifo_rd_data;
  logic [FIFO_AW:0] fifo_fill;
  logic asm_phase_q;
  logic asm_run_q;
  logic [PAIR_W-1:0] asm_pair_q;
  logic [SAMPLE_W-1:0] asm_out_q;
  logic [SAMPLE_W-1:0] pipe_q [LAT_PAD];

  assign running = en_q && receiver_loop_on_q;
  assign clk_tap = clock_path_delay_q[TAP_W-1:0];
  assign early_tap = clk_tap + 1'b1;
  assign smp_tap = sample_path_delay_q[TAP_W-1:0];
  // Narrower skew gives a longer averaging period, hence a slower loop
  assign avg_len = {1'b0, AVG_STEP} * {3'b000, SKEW_TOP - window_skew_width_q} + {1'b0, AVG_STEP};
  assign avg_done = (avg_cnt_q == avg_len);
  assign too_early = (early_votes_q > {1'b0, avg_len[6:1]});
  assign too_late = (late_votes_q <= {1'b0, avg_len[6:1]});
  assign centred = !too_early && !too_late;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
      ret_div_q <= '0;
      returned_q <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      // Separate divider for the return clock: reset and stepped with div_q, so it always stays in phase with it
      ret_div_q <= ret_div_q + 1'b1;
      returned_q <= ret_div_q[1];
    end
  end
  assign link.returned_clock_out = returned_q;

  // Host data and clock share hclk, so no synchroniser; the taps model the delay lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_hist_q <= '0;
    end else begin
      clk_hist_q <= {clk_hist_q[HIST_DEPTH-2:0], link.forwarded_data_clock};
    end
  end

  always_ff @(posedge hclk) begin
    data_hist_q[0] <= {link.odd_sample_port, link.even_sample_port};
    for (int i = 1; i < HIST_DEPTH; i++) begin
      data_hist_q[i] <= data_hist_q[i-1];
    end
  end

  // Early and late window samples at the divider's reference phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      early_window_sample_q <= 1'b0;
      late_window_sample_q <= 1'b0;
    end else if (div_q == 2'd0) begin
      early_window_sample_q <= clk_hist_q[early_tap];
      late_window_sample_q <= clk_hist_q[clk_tap];
    end
  end

  // Vote counters over one averaging period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg_cnt_q <= '0;
      early_votes_q <= '0;
      late_votes_q <= '0;
    end else if (!running || avg_done) begin
      avg_cnt_q <= '0;
      early_votes_q <= '0;
      late_votes_q <= '0;
    end else if (div_q == 2'd1) begin
      avg_cnt_q <= avg_cnt_q + 1'b1;
      early_votes_q <= early_votes_q + {6'h0, early_window_sample_q};
      late_votes_q <= late_votes_q + {6'h0, late_window_sample_q};
    end
  end

  // Configuration port writes, and the controller that overwrites the delays
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
      receiver_loop_on_q <= 1'b0;
      flag_rst_q <= 1'b0;
      window_skew_width_q <= SKEW_RST;
    end else if (link.cfg_wr) begin
      if (link.cfg_addr == A_RX_CTRL) begin
        en_q <= link.cfg_wdata[B_EN];
        receiver_loop_on_q <= link.cfg_wdata[B_LOOP_ON];
        flag_rst_q <= link.cfg_wdata[B_FLAG_RST];
      end
      if (link.cfg_addr == A_WIN_SKEW) begin
        window_skew_width_q <= link.cfg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_path_delay_q <= DLY_RST;
      sample_path_delay_q <= DLY_RST;
      state_q <= ST_OFF;
      miss_q <= '0;
    end else if (link.cfg_wr && !running && (link.cfg_addr == A_CLK_DLY)) begin
      clock_path_delay_q <= link.cfg_wdata;
    end else if (link.cfg_wr && !running && (link.cfg_addr == A_SMP_DLY)) begin
      sample_path_delay_q <= link.cfg_wdata;
    end else begin
      case (state_q)
        ST_OFF: begin
          miss_q <= '0;
          if (running) begin
            state_q <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (!running) begin
            state_q <= ST_OFF;
          end else if (avg_done && centred) begin
            state_q <= ST_TRACK;
          end else if (avg_done) begin
            // Step until the window straddles the forwarded clock edge
            clock_path_delay_q <= clock_path_delay_q + 1'b1;
            sample_path_delay_q <= clock_path_delay_q + 1'b1;
          end
        end
        ST_TRACK: begin
          if (!running) begin
            state_q <= ST_OFF;
          end else if (avg_done && centred) begin
            miss_q <= '0;
          end else if (avg_done) begin
            miss_q <= miss_q + 1'b1;
            if (miss_q == LOST_LIMIT || clock_path_delay_q == '0 || clock_path_delay_q == DLY_MAX) begin
              state_q <= ST_LOST;
            end else if (too_early) begin
              clock_path_delay_q <= clock_path_delay_q - 1'b1;
              sample_path_delay_q <= clock_path_delay_q - 1'b1;
            end else begin
              clock_path_delay_q <= clock_path_delay_q + 1'b1;
              sample_path_delay_q <= clock_path_delay_q + 1'b1;
            end
          end
        end
        ST_LOST: begin
          // Waits for software to drop enable or loop-on, then set both again
          if (!running) begin
            state_q <= ST_OFF;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Same condition that moves the controller from track to lost
  assign lose_lock = (state_q == ST_TRACK) && running && avg_done && !centred &&
    (miss_q == LOST_LIMIT || clock_path_delay_q == '0 || clock_path_delay_q == DLY_MAX);

  // Sticky lost flag, cleared by the reset bit written high then low; a new loss wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lost_q <= 1'b0;
    end else if (lose_lock) begin
      lost_q <= 1'b1;
    end else if (link.cfg_wr && link.cfg_addr == A_RX_CTRL && flag_rst_q && !link.cfg_wdata[B_FLAG_RST]) begin
      lost_q <= 1'b0;
    end
  end
  assign link.lock_irq = lost_q;
  assign receiver_locked = (state_q == ST_TRACK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (link.cfg_rd) begin
      case (link.cfg_addr)
        A_WIN_STATUS: rdata_q <= {5'd0, early_window_sample_q, 1'b0, late_window_sample_q};
        A_RX_CTRL: rdata_q <= {5'd0, flag_rst_q, receiver_loop_on_q, en_q};
        A_CLK_DLY: rdata_q <= clock_path_delay_q;
        A_SMP_DLY: rdata_q <= sample_path_delay_q;
        A_WIN_SKEW: rdata_q <= {4'd0, window_skew_width_q};
        A_RX_STATUS: rdata_q <= {4'd0, receiver_locked, 1'b0, lost_q, receiver_locked};
        default: rdata_q <= '0;
      endcase
    end
  end
  assign link.cfg_rdata = rdata_q;

  // Capture at 90 and 270 degrees of the divider: both forwarded clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_lo_q <= 1'b0;
      cap_valid_q <= 1'b0;
      cap_even_q <= MIDSCALE;
      cap_odd_q <= MIDSCALE;
    end else begin
      cap_valid_q <= 1'b0;
      if (div_q[0]) begin
        cap_lo_q <= ~cap_lo_q;
        cap_even_q <= data_hist_q[smp_tap][SAMPLE_W-1:0];
        cap_odd_q <= data_hist_q[smp_tap][PAIR_W-1:SAMPLE_W];
        cap_valid_q <= receiver_locked;
      end
    end
  end

  elastic_fifo u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .flush(!receiver_locked),
    .wr_valid(cap_valid_q),
    .wr_ready(fifo_wr_ready),
    .wr_data({cap_odd_q, cap_even_q}),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data),
    .fill(fifo_fill)
  );

  // Assembler starts once two pairs are banked, so capture jitter is absorbed
  assign fifo_rd_ready = asm_run_q && !asm_phase_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asm_run_q <= 1'b0;
      asm_phase_q <= 1'b0;
      asm_pair_q <= '0;
      asm_out_q <= MIDSCALE;
    end else if (!receiver_locked) begin
      asm_run_q <= 1'b0;
      asm_phase_q <= 1'b0;
      asm_out_q <= MIDSCALE;
    end else begin
      if (fifo_fill >= (FIFO_AW+1)'(2)) begin
        asm_run_q <= 1'b1;
      end
      if (asm_run_q && !asm_phase_q && fifo_rd_valid) begin
        asm_pair_q <= fifo_rd_data;
        asm_out_q <= fifo_rd_data[SAMPLE_W-1:0];
        asm_phase_q <= 1'b1;
      end else if (asm_phase_q) begin
        asm_out_q <= asm_pair_q[PAIR_W-1:SAMPLE_W];
        asm_phase_q <= 1'b0;
      end
    end
  end

  // Padding pipeline that brings the total port-to-output delay to about 78 cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < LAT_PAD; i++) begin
        pipe_q[i] <= MIDSCALE;
      end
    end else if (!receiver_locked) begin
      // Flushed so that no stale data leaves after a loss of lock
      for (int i = 0; i < LAT_PAD; i++) begin
        pipe_q[i] <= MIDSCALE;
      end
    end else begin
      pipe_q[0] <= asm_out_q;
      for (int i = 1; i < LAT_PAD; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end
  assign converter_sample = pipe_q[LAT_PAD-1];
endmodule : ddr_port_receiver
`default_nettype wire

/* File: hw/ddr_port_host.sv */
// Host end: AHB-Lite controlled config master and DDR sample source
`timescale 1ns/1ps
`default_nettype none
module ddr_port_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [dual_ddr_pkg::SAMPLE_W-1:0] even_sample_in,
  input wire logic [dual_ddr_pkg::SAMPLE_W-1:0] odd_sample_in,
  output logic sample_take,
  ddr_link_if.host link
);
  import dual_ddr_pkg::*;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic stream_en_q;
  logic cfg_wr_q;
  logic cfg_rd_q;
  logic cfg_rd_dly_q;
  logic [7:0] cfg_addr_q;
  logic [7:0] cfg_wdata_q;
  logic [7:0] last_rd_q;
  logic ret_seen_q;
  logic [31:0] hrdata_q;
  logic [1:0] tx_div_q;
  logic fwd_clk_q;
  logic [SAMPLE_W-1:0] even_q;
  logic [SAMPLE_W-1:0] odd_q;
  logic accept;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = !rd_pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_pend_q <= accept && hwrite;
      if (hready) begin
        rd_pend_q <= accept && !hwrite;
      end else begin
        rd_pend_q <= 1'b0;
      end
      if (accept) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // Register writes and config launches; a launch lasts one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stream_en_q <= 1'b0;
      cfg_wr_q <= 1'b0;
      cfg_rd_q <= 1'b0;
      cfg_addr_q <= '0;
      cfg_wdata_q <= '0;
    end else begin
      cfg_wr_q <= 1'b0;
      cfg_rd_q <= 1'b0;
      if (wr_pend_q && addr_q == H_CTRL) begin
        stream_en_q <= hwdata[0];
      end
      if (wr_pend_q && addr_q == H_CFG) begin
        cfg_addr_q <= hwdata[15:8];
        cfg_wdata_q <= hwdata[7:0];
        cfg_wr_q <= !hwdata[H_CFG_RD];
        cfg_rd_q <= hwdata[H_CFG_RD];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_rd_dly_q <= 1'b0;
      last_rd_q <= '0;
      ret_seen_q <= 1'b0;
      hrdata_q <= '0;
    end else begin
      cfg_rd_dly_q <= cfg_rd_q;
      if (cfg_rd_dly_q) begin
        last_rd_q <= link.cfg_rdata;
      end
      if (link.returned_clock_out) begin
        ret_seen_q <= 1'b1;
      end
      if (rd_pend_q) begin
        case (addr_q)
          H_CTRL: hrdata_q <= {31'd0, stream_en_q};
          H_CFG: hrdata_q <= {16'd0, cfg_addr_q, cfg_wdata_q};
          H_STATUS: hrdata_q <= {22'd0, ret_seen_q, link.lock_irq, last_rd_q};
          default: hrdata_q <= '0;
        endcase
      end
    end
  end

  // Forwarded clock built like a data line: toggles with each data word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_div_q <= '0;
      fwd_clk_q <= 1'b0;
      even_q <= MIDSCALE;
      odd_q <= MIDSCALE;
    end else begin
      tx_div_q <= tx_div_q + 1'b1;
      if (tx_div_q[0]) begin
        fwd_clk_q <= ~fwd_clk_q;
        if (stream_en_q) begin
          even_q <= even_sample_in;
          odd_q <= odd_sample_in;
        end
      end
    end
  end
  assign sample_take = stream_en_q && tx_div_q[0];
  assign link.forwarded_data_clock = fwd_clk_q;
  assign link.even_sample_port = even_q;
  assign link.odd_sample_port = odd_q;
  assign link.cfg_wr = cfg_wr_q;
  assign link.cfg_rd = cfg_rd_q;
  assign link.cfg_addr = cfg_addr_q;
  assign link.cfg_wdata = cfg_wdata_q;
endmodule : ddr_port_host
`default_nettype wire

/* File: dv/ddr_link_sva.sv */
// Assertions on the link between host end and receiver end
`timescale 1ns/1ps
`default_nettype none
module ddr_link_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [dual_ddr_pkg::SAMPLE_W-1:0] even_sample_port,
  input wire logic [dual_ddr_pkg::SAMPLE_W-1:0] odd_sample_port,
  input wire logic forwarded_data_clock,
  input wire logic returned_clock_out,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_rdata,
  input wire logic lock_irq,
  input wire logic [dual_ddr_pkg::SAMPLE_W-1:0] converter_sample,
  input wire logic receiver_locked
);
  import dual_ddr_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A write to the control register may stop the loop without any loss
  wire logic ctrl_wr = cfg_wr && (cfg_addr == A_RX_CTRL);
  // One cycle of grace after loss of lock for the output register
  a_unlocked_mid: assert property (!receiver_locked && !$past(receiver_locked) |-> converter_sample == MIDSCALE)
    else $error("output not midscale while unlocked");
  a_ret_period: assert property ($rose(returned_clock_out) |-> ##2 !returned_clock_out ##2 returned_clock_out)
    else $error("returned clock period not four cycles");
  a_fwd_hold: assert property ($changed(forwarded_data_clock) |=> $stable(forwarded_data_clock))
    else $error("forwarded clock level held one cycle only");
  a_data_with_clk: assert property ($changed(even_sample_port) || $changed(odd_sample_port) |-> $changed(forwarded_data_clock))
    else $error("data moved without a forwarded clock edge");
  a_rdata_timing: assert property ($changed(cfg_rdata) |-> $past(cfg_rd))
    else $error("config read data moved without a read");
  a_cfg_excl: assert property (!(cfg_wr && cfg_rd))
    else $error("config read and write together");
  a_irq_sticky: assert property (lock_irq && !(cfg_wr && cfg_addr == A_RX_CTRL) |=> lock_irq)
    else $error("lost lock flag cleared by itself");
  a_lost_irq: assert property ($fell(receiver_locked) && !$past(ctrl_wr, 2) |-> ##[0:2] lock_irq)
    else $error("loss of lock not flagged");
  c_lock: cover property ($rose(receiver_locked));
  c_cfg_rd: cover property (cfg_rd);
  c_data: cover property (receiver_locked && converter_sample != MIDSCALE);
endmodule : ddr_link_sva
`default_nettype wire

/* File: dv/dual_ddr_port_receiver_tb.sv */
// Self-checking bench: AHB host end driving the receiver end over the link
`timescale 1ns/1ps
`default_nettype none
module dual_ddr_port_receiver_tb;
  import dual_ddr_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, sample_take, receiver_locked;
  wire logic [SAMPLE_W-1:0] converter_sample;
  logic [SAMPLE_W-1:0] even_in = 0, odd_in = 0, exp_q[$];
  int stamp_q[$], seed = 83, mismatches = 0, compares = 0, cyc = 0, lat, i;
  ddr_link_if link ();
  ddr_port_host i_ddr_port_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .even_sample_in(even_in), .odd_sample_in(odd_in), .sample_take(sample_take), .link(link));
  ddr_port_receiver i_ddr_port_receiver (.hclk(hclk), .hresetn(hresetn), .link(link),
    .converter_sample(converter_sample), .receiver_locked(receiver_locked));
  ddr_link_sva i_ddr_link_sva (.hclk(hclk), .hresetn(hresetn), .even_sample_port(link.even_sample_port),
    .odd_sample_port(link.odd_sample_port), .forwarded_data_clock(link.forwarded_data_clock),
    .returned_clock_out(link.returned_clock_out), .cfg_wr(link.cfg_wr), .cfg_rd(link.cfg_rd),
    .cfg_addr(link.cfg_addr), .cfg_rdata(link.cfg_rdata), .lock_irq(link.lock_irq),
    .converter_sample(converter_sample), .receiver_locked(receiver_locked));
  initial begin
    forever #2 hclk = ~hclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // Address phase held until hready, then data phase held until hready again
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task dev_wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1, {24'h0, H_CFG}, {16'h0, a, d}, rd);
  endtask : dev_wr
  task dev_rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1, {24'h0, H_CFG}, {15'h0, 1'b1, a, 8'h00}, r);
    repeat (6) @(posedge hclk);
    ahb(0, {24'h0, H_STATUS}, 0, r);
  endtask : dev_rd
  // Model of the user stream: each taken pair becomes even then odd
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 60000) begin
      mismatches++;
      end_of_test;
    end else if (sample_take === 1'b1) begin
      exp_q.push_back(even_in);
      exp_q.push_back(odd_in);
      stamp_q.push_back(cyc);
      stamp_q.push_back(cyc + 1);
      even_in <= SAMPLE_W'($random(seed));
      odd_in <= SAMPLE_W'($random(seed));
    end
  end
  initial begin
    repeat (8) @(posedge hclk);
    check(converter_sample, MIDSCALE);
    check({link.returned_clock_out, receiver_locked, link.lock_irq}, 0);
    hresetn <= 1;
    @(posedge hclk);
    ahb(1, {24'h0, H_CTRL}, 1, rd);
    ahb(0, {24'h0, H_CTRL}, 0, rd);
    check(rd[0], 1);
    ahb(0, 32'h40, 0, rd);
    check(rd, 0);
    dev_rd(A_RX_STATUS, rd);
    check(rd[7:0], 0);
    dev_wr(A_WIN_SKEW, 8'h72);
    dev_wr(A_RX_CTRL, 8'h00);
    // Second pass relocks after a software stop, as a loop-on restart does
    repeat (2) begin
      dev_wr(A_RX_CTRL, 8'h02);
      dev_wr(A_RX_CTRL, 8'h03);
      i = 0;
      while (receiver_locked !== 1'b1 && i < 400) begin
        repeat (100) @(posedge hclk);
        i++;
      end
      dev_rd(A_RX_STATUS, rd);
      check(rd[7:0], 8'h09);
      dev_rd(A_WIN_STATUS, rd);
      check(rd[2:0] & 3'h5, 3'h1);
      ahb(0, {24'h0, H_STATUS}, 0, rd);
      check(rd[9:8], 2'b10);
      repeat (300) @(posedge hclk);
      // Only samples young enough to be in flight may be matched
      while (exp_q.size() > 0 && (cyc - stamp_q[0] > 86 || exp_q[0] !== converter_sample)) begin
        void'(exp_q.pop_front());
        void'(stamp_q.pop_front());
      end
      check(exp_q.size() > 0, 1);
      lat = cyc - stamp_q[0];
      check(lat >= 70 && lat <= 86, 1);
      for (i = 0; i < 400 && exp_q.size() > 0; i++) begin
        check(converter_sample, exp_q.pop_front());
        void'(stamp_q.pop_front());
        @(posedge hclk);
      end
      check(receiver_locked, 1);
      dev_wr(A_RX_CTRL, 8'h02);
      repeat (6) @(posedge hclk);
      check(receiver_locked, 0);
      check(converter_sample, MIDSCALE);
    end
    end_of_test;
  end
endmodule : dual_ddr_port_receiver_tb
`default_nettype wire
